/* agu_pkg.sv */
package agu_pkg;

   // ************************************************************
   // Field widths
   // ************************************************************
   localparam int AGU_LONG_W = 16;
   localparam int AGU_SHORT_W = 5;
   localparam int AGU_SCALED_W = 12;
   localparam int AGU_PTR_COUNT = 16;

   // ************************************************************
   // Long field layout
   // ************************************************************
   localparam int AGU_L_BASE_LSB = 0;
   localparam int AGU_L_INDEX_LSB = 4;
   localparam int AGU_L_SHIFT_LSB = 6;
   localparam int AGU_L_WBPTR_LSB = 8;
   localparam int AGU_L_U10_LSB = 4;
   localparam int AGU_L_U8_LSB = 4;
   localparam int AGU_L_U7_LSB = 6;
   localparam int AGU_L_N13_LSB = 0;
   localparam int AGU_L_OP_LSB = 12;
   localparam logic [1:0] AGU_L_OP2_OFFS = 2'h0;
   localparam logic [1:0] AGU_L_OP2_SCALED = 2'h1;
   localparam logic [2:0] AGU_L_OP3_OFFS_INC = 3'h4;
   localparam logic [2:0] AGU_L_OP3_STACK_REL = 3'h5;
   localparam logic [3:0] AGU_L_OP4_POST_INC = 4'hc;
   localparam logic [3:0] AGU_L_OP4_POST_DEC = 4'hd;
   localparam logic [3:0] AGU_L_OP4_PRE_DEC = 4'he;
   localparam logic [3:0] AGU_L_OP4_INDEXED = 4'hf;

   // ************************************************************
   // Short and scaled field layout
   // ************************************************************
   localparam int AGU_S_PTR_LSB = 0;
   localparam int AGU_S_OP_LSB = 2;
   localparam logic [3:0] AGU_S_BASE_FIRST = 4'h4;
   localparam logic [2:0] AGU_S_OP_PLAIN = 3'h0;
   localparam logic [2:0] AGU_S_OP_IDX0 = 3'h1;
   localparam logic [2:0] AGU_S_OP_IDX1 = 3'h2;
   localparam logic [2:0] AGU_S_OP_POST_INC = 3'h3;
   localparam logic [2:0] AGU_S_OP_POST_DEC = 3'h4;
   localparam logic [2:0] AGU_S_OP_PRE_DEC = 3'h5;
   localparam logic [2:0] AGU_S_OP_REG_INC0 = 3'h6;
   localparam logic [2:0] AGU_S_OP_REG_INC1 = 3'h7;
   localparam int AGU_C_BASE_LSB = 0;
   localparam int AGU_C_U8_LSB = 4;

   // ************************************************************
   // Special pointers and reset values
   // ************************************************************
   localparam logic [3:0] AGU_PTR_ZERO = 4'h0;
   localparam logic [3:0] AGU_PTR_ONE = 4'h1;
   localparam logic [3:0] AGU_STACK_PTR = 4'hf;
   localparam logic [31:0] AGU_PTR_RESET = 32'h0000_0000;
   localparam logic [31:0] AGU_ADDR_RESET = 32'h0000_0000;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      AGU_SEL_DIRECT = 2'h0,
      AGU_SEL_LONG = 2'h1,
      AGU_SEL_SHORT = 2'h2,
      AGU_SEL_SCALED = 2'h3
   } agu_field_sel_type;

   typedef enum logic [1:0] {
      AGU_IDLE = 2'b01,
      AGU_CALC = 2'b10
   } agu_state_type;

   typedef struct packed {
      logic ptr_en;
      logic [3:0] ptr;
      logic [31:0] imm;
   } agu_direct_type;

   typedef struct packed {
      agu_field_sel_type sel;
      logic [AGU_LONG_W-1:0] long_mode_field;
      logic [AGU_SHORT_W-1:0] short_mode_field;
      logic [AGU_SCALED_W-1:0] scaled_mode_field;
      agu_direct_type direct_mode_field;
      logic [1:0] size_log2;
   } agu_req_type;

   typedef struct packed {
      logic en;
      logic [3:0] idx;
      logic [31:0] data;
   } agu_wb_type;

endpackage : agu_pkg

/* agu_ptr_file.sv */
module agu_ptr_file (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Read ports
   input wire logic [3:0] rd_a_idx_in,
   input wire logic [3:0] rd_b_idx_in,
   output logic [31:0] rd_a_out,
   output logic [31:0] rd_b_out,
   // Write port
   input wire agu_pkg::agu_wb_type wr_in
);
   import agu_pkg::*;

   logic [31:0] ptr_q [AGU_PTR_COUNT];
   logic [31:0] rd_a_d;
   logic [31:0] rd_b_d;

   // ************************************************************
   // Pointer storage
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < AGU_PTR_COUNT; gi++) begin : g_ptr
         // One pointer word
         always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               ptr_q[gi] <= AGU_PTR_RESET;
            end else if (wr_in.en && (wr_in.idx == 4'(gi))) begin
               ptr_q[gi] <= wr_in.data;
            end
         end
      end
   endgenerate

   // Read with forwarding of a same-cycle write
   assign rd_a_d = (wr_in.en && wr_in.idx == rd_a_idx_in) ? wr_in.data : ptr_q[rd_a_idx_in];
   assign rd_b_d = (wr_in.en && wr_in.idx == rd_b_idx_in) ? wr_in.data : ptr_q[rd_b_idx_in];

   // Registered read data
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_a_out <= AGU_PTR_RESET;
         rd_b_out <= AGU_PTR_RESET;
      end else begin
         rd_a_out <= rd_a_d;
         rd_b_out <= rd_b_d;
      end
   end

endmodule : agu_ptr_file

/* agu_core.sv */
module agu_core (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Request from the instruction decoder
   input wire logic req_valid_in,
   input wire agu_pkg::agu_req_type req_in,
   output logic req_ready_out,
   // Pointer loads from other instructions
   input wire logic ptr_load_valid_in,
   input wire logic [3:0] ptr_load_idx_in,
   input wire logic [31:0] ptr_load_data_in,
   output logic ptr_load_ready_out,
   // Address to the load/store path
   output logic addr_valid_out,
   output logic [31:0] addr_out,
   // Pointer write-back seen on the last calculation
   output agu_pkg::agu_wb_type writeback_out
);
   import agu_pkg::*;

   // ************************************************************
   // Helpers
   // ************************************************************

   // Amount encoded as value minus one
   function automatic logic [31:0] agu_minus_one_amount(input logic [12:0] f);
      agu_minus_one_amount = {19'h0, f} + 32'h1;
   endfunction : agu_minus_one_amount

   // Short field base pointer, always one of 4 to 7
   function automatic logic [3:0] agu_short_base(input logic [AGU_SHORT_W-1:0] f);
      agu_short_base = AGU_S_BASE_FIRST | {2'h0, f[AGU_S_PTR_LSB +: 2]};
   endfunction : agu_short_base

   // ************************************************************
   // State
   // ************************************************************
   agu_state_type state_q;
   agu_state_type state_d;
   agu_req_type req_q;
   logic addr_valid_q;
   logic [31:0] addr_q;
   logic [31:0] addr_d;
   agu_wb_type wb_q;
   agu_wb_type wb_d;
   agu_wb_type file_wr;
   logic [3:0] rd_base_idx;
   logic [3:0] rd_index_idx;
   logic [31:0] base_val;
   logic [31:0] index_val;
   logic accept;

   // Long field slices of the held request
   logic [AGU_LONG_W-1:0] lf;
   logic [3:0] l_op4;
   logic [3:0] l_base;
   logic [1:0] l_shift;
   logic [3:0] l_wbptr;
   logic [31:0] l_u10;
   logic [31:0] l_u10_x4;
   logic [31:0] l_u8;
   logic [31:0] l_u7;
   logic [31:0] l_n8;
   logic [31:0] l_n13;
   logic [31:0] l_indexed_sum;

   // Short and scaled field slices
   logic [AGU_SHORT_W-1:0] sf;
   logic [2:0] s_op;
   logic [31:0] s_step;
   logic [31:0] s_scaled_idx;
   logic [31:0] c_u8_x4;

   // Request slices for the read port selection
   logic [AGU_LONG_W-1:0] in_lf;
   logic [2:0] in_s_op;

   // ************************************************************
   // Handshake
   // ************************************************************

   // One request in flight; write-back lands before the next read
   assign req_ready_out = (state_q == AGU_IDLE);
   assign accept = req_valid_in && req_ready_out;
   assign ptr_load_ready_out = (state_q == AGU_IDLE);
   assign state_d = accept ? AGU_CALC : AGU_IDLE;

   // ************************************************************
   // Read port selection from the incoming request
   // ************************************************************
   assign in_lf = req_in.long_mode_field;
   assign in_s_op = req_in.short_mode_field[AGU_S_OP_LSB +: 3];

   // Base pointer to read
   always_comb begin
      rd_base_idx = AGU_PTR_ZERO;
      case (req_in.sel)
         AGU_SEL_DIRECT: rd_base_idx = req_in.direct_mode_field.ptr;
         AGU_SEL_LONG: begin
            if (in_lf[AGU_L_OP_LSB+1 +: 3] == AGU_L_OP3_STACK_REL) begin
               rd_base_idx = AGU_STACK_PTR;
            end else begin
               rd_base_idx = in_lf[AGU_L_BASE_LSB +: 4];
            end
         end
         AGU_SEL_SHORT: rd_base_idx = agu_short_base(req_in.short_mode_field);
         AGU_SEL_SCALED: rd_base_idx = req_in.scaled_mode_field[AGU_C_BASE_LSB +: 4];
         default: rd_base_idx = AGU_PTR_ZERO;
      endcase
   end

   // Index pointer to read
   always_comb begin
      rd_index_idx = AGU_PTR_ZERO;
      if (req_in.sel == AGU_SEL_LONG) begin
         rd_index_idx = {2'h0, in_lf[AGU_L_INDEX_LSB +: 2]};
      end else if (req_in.sel == AGU_SEL_SHORT) begin
         if (in_s_op == AGU_S_OP_IDX1 || in_s_op == AGU_S_OP_REG_INC1) begin
            rd_index_idx = AGU_PTR_ONE;
         end else begin
            rd_index_idx = AGU_PTR_ZERO;
         end
      end
   end

   // ************************************************************
   // Field slices of the held request
   // ************************************************************
   assign lf = req_q.long_mode_field;
   assign l_op4 = lf[AGU_L_OP_LSB +: 4];
   assign l_base = lf[AGU_L_BASE_LSB +: 4];
   assign l_shift = lf[AGU_L_SHIFT_LSB +: 2];
   assign l_wbptr = lf[AGU_L_WBPTR_LSB +: 4];
   assign l_u10 = {22'h0, lf[AGU_L_U10_LSB +: 10]};
   assign l_u10_x4 = {20'h0, lf[AGU_L_U10_LSB +: 10], 2'h0};
   assign l_u8 = {24'h0, lf[AGU_L_U8_LSB +: 8]};
   assign l_u7 = {25'h0, lf[AGU_L_U7_LSB +: 7]};
   assign l_n8 = agu_minus_one_amount({5'h0, lf[AGU_L_U8_LSB +: 8]});
   assign l_n13 = agu_minus_one_amount(lf[AGU_L_N13_LSB +: 13]);
   assign l_indexed_sum = base_val + (index_val << l_shift);
   assign sf = req_q.short_mode_field;
   assign s_op = sf[AGU_S_OP_LSB +: 3];
   assign s_step = 32'h1 << req_q.size_log2;
   assign s_scaled_idx = index_val << req_q.size_log2;
   assign c_u8_x4 = {22'h0, req_q.scaled_mode_field[AGU_C_U8_LSB +: 8], 2'h0};

   // ************************************************************
   // Address and write-back calculation
   // ************************************************************

   // All field modes, 32-bit wrapping arithmetic throughout
   always_comb begin
      addr_d = base_val;
      wb_d = '0;
      case (req_q.sel)
         AGU_SEL_DIRECT: begin
            if (req_q.direct_mode_field.ptr_en) begin
               addr_d = base_val + {4'h0, req_q.direct_mode_field.imm[27:0]};
            end else begin
               addr_d = req_q.direct_mode_field.imm;
            end
         end
         AGU_SEL_SCALED: addr_d = base_val + c_u8_x4;
         AGU_SEL_LONG: begin
            if (lf[AGU_L_OP_LSB+2 +: 2] == AGU_L_OP2_OFFS) begin
               addr_d = base_val + l_u10;
            end else if (lf[AGU_L_OP_LSB+2 +: 2] == AGU_L_OP2_SCALED) begin
               addr_d = base_val + l_u10_x4;
            end else if (lf[AGU_L_OP_LSB+1 +: 3] == AGU_L_OP3_OFFS_INC) begin
               addr_d = base_val + l_u7;
               wb_d = '{en: 1'b1, idx: l_base, data: base_val + index_val};
            end else if (lf[AGU_L_OP_LSB+1 +: 3] == AGU_L_OP3_STACK_REL) begin
               addr_d = base_val - l_n13;
            end else begin
               case (l_op4)
                  AGU_L_OP4_POST_INC: begin
                     addr_d = base_val;
                     wb_d = '{en: 1'b1, idx: l_base, data: base_val + l_u8};
                  end
                  AGU_L_OP4_POST_DEC: begin
                     addr_d = base_val;
                     wb_d = '{en: 1'b1, idx: l_base, data: base_val - l_n8};
                  end
                  AGU_L_OP4_PRE_DEC: begin
                     addr_d = base_val - l_n8;
                     wb_d = '{en: 1'b1, idx: l_base, data: base_val - l_n8};
                  end
                  AGU_L_OP4_INDEXED: begin
                     addr_d = l_indexed_sum;
                     wb_d = '{en: (l_wbptr != AGU_STACK_PTR), idx: l_wbptr,
                              data: l_indexed_sum};
                  end
                  default: addr_d = base_val;
               endcase
            end
         end
         AGU_SEL_SHORT: begin
            case (s_op)
               AGU_S_OP_PLAIN: addr_d = base_val;
               AGU_S_OP_IDX0, AGU_S_OP_IDX1: addr_d = base_val + s_scaled_idx;
               AGU_S_OP_POST_INC: begin
                  addr_d = base_val;
                  wb_d = '{en: 1'b1, idx: agu_short_base(sf), data: base_val + s_step};
               end
               AGU_S_OP_POST_DEC: begin
                  addr_d = base_val;
                  wb_d = '{en: 1'b1, idx: agu_short_base(sf), data: base_val - s_step};
               end
               AGU_S_OP_PRE_DEC: begin
                  addr_d = base_val - s_step;
                  wb_d = '{en: 1'b1, idx: agu_short_base(sf), data: base_val - s_step};
               end
               AGU_S_OP_REG_INC0, AGU_S_OP_REG_INC1: begin
                  addr_d = base_val;
                  wb_d = '{en: 1'b1, idx: agu_short_base(sf), data: base_val + index_val};
               end
               default: addr_d = base_val;
            endcase
         end
         default: addr_d = base_val;
      endcase
   end

   // ************************************************************
   // Pointer file
   // ************************************************************

   // Write-back in the calculation cycle, outside loads only when idle
   always_comb begin
      file_wr = '0;
      if (state_q == AGU_CALC) begin
         file_wr = wb_d;
      end else if (ptr_load_valid_in) begin
         file_wr = '{en: 1'b1, idx: ptr_load_idx_in, data: ptr_load_data_in};
      end
   end

   agu_ptr_file u_ptr_file (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .rd_a_idx_in(rd_base_idx),
      .rd_b_idx_in(rd_index_idx),
      .rd_a_out(base_val),
      .rd_b_out(index_val),
      .wr_in(file_wr)
   );

   // ************************************************************
   // Registers
   // ************************************************************

   // Control state and held request
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= AGU_IDLE;
         req_q <= '0;
      end else begin
         state_q <= state_d;
         if (accept) begin
            req_q <= req_in;
         end
      end
   end

   // Address result, one-cycle valid pulse
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         addr_valid_q <= 1'b0;
         addr_q <= AGU_ADDR_RESET;
         wb_q <= '0;
      end else begin
         addr_valid_q <= (state_q == AGU_CALC);
         if (state_q == AGU_CALC) begin
            addr_q <= addr_d;
            wb_q <= wb_d;
         end
      end
   end

   assign addr_valid_out = addr_valid_q;
   assign addr_out = addr_q;
   assign writeback_out = wb_q;

endmodule : agu_core

/* agu_core_checker.sv */
module agu_core_checker (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Request side
   input wire logic req_valid_in,
   input wire agu_pkg::agu_req_type req_in,
   input wire logic req_ready_out,
   // Pointer loads
   input wire logic ptr_load_valid_in,
   input wire logic [3:0] ptr_load_idx_in,
   input wire logic [31:0] ptr_load_data_in,
   input wire logic ptr_load_ready_out,
   // Results
   input wire logic addr_valid_out,
   input wire logic [31:0] addr_out,
   input wire agu_pkg::agu_wb_type writeback_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import agu_pkg::*;

   // ******
   // Helpers
   // ******
   logic take;
   logic [15:0] lf;

   // Request taken this edge and its long field
   assign take = req_valid_in && req_ready_out;
   assign lf = req_in.long_mode_field;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   // ******
   // Handshake and timing
   // ******
   busy_after_take_a: assert property (take |=> !req_ready_out)
      else $error("ready stayed high after a take");
   addr_latency_a: assert property (take |=> !addr_valid_out ##1 addr_valid_out)
      else $error("address pulse not two cycles after take");
   addr_cause_a: assert property (addr_valid_out |-> $past(take, 2))
      else $error("address pulse without a request");
   result_hold_a: assert property (!addr_valid_out |-> $stable(addr_out))
      else $error("address changed without a pulse");
   load_ready_a: assert property (ptr_load_ready_out == req_ready_out)
      else $error("load ready differs from request ready");

   // ******
   // Address and write-back relations
   // ******
   direct_addr_a: assert property (take && req_in.sel == AGU_SEL_DIRECT &&
      !req_in.direct_mode_field.ptr_en |-> ##2 addr_out == $past(req_in.direct_mode_field.imm, 2))
      else $error("direct address not the immediate");
   stack_nowb_a: assert property (take && req_in.sel == AGU_SEL_LONG && lf[15:13] == 3'h5
      |-> ##2 !writeback_out.en)
      else $error("stack relative wrote a pointer");
   post_inc_a: assert property (take && req_in.sel == AGU_SEL_LONG && lf[15:12] == 4'hc
      |-> ##2 writeback_out.en && writeback_out.data - addr_out == {24'h0, $past(lf[11:4], 2)})
      else $error("post increment step wrong");
   pre_dec_a: assert property (take && req_in.sel == AGU_SEL_LONG && lf[15:12] == 4'he
      |-> ##2 writeback_out.en && writeback_out.data == addr_out)
      else $error("pre decrement address not the new pointer");
   short_step_a: assert property (take && req_in.sel == AGU_SEL_SHORT &&
      req_in.short_mode_field[4:2] == 3'h3 |-> ##2
      writeback_out.data - addr_out == (32'h1 << $past(req_in.size_log2, 2)))
      else $error("short post increment step wrong");
endmodule : agu_core_checker

/* agu_lsu_model.sv */
module agu_lsu_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Address from the generator
   input wire logic addr_valid_in,
   input wire logic [31:0] addr_in,
   // Capture for the bench
   output logic [31:0] last_addr_out,
   output logic [15:0] n_access_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Memory path takes every pulse at once, no stall
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         last_addr_out <= 32'h0;
         n_access_out <= 16'h0;
      end else if (addr_valid_in) begin
         last_addr_out <= addr_in;
         n_access_out <= n_access_out + 16'h1;
      end
   end
endmodule : agu_lsu_model

/* address_generation_unit_tb.sv */
module address_generation_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import agu_pkg::*;

   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic req_valid_in = 1'b0;
   agu_req_type req_in = '0;
   logic req_ready_out;
   logic ptr_load_valid_in = 1'b0;
   logic [3:0] ptr_load_idx_in = 4'h0;
   logic [31:0] ptr_load_data_in = 32'h0;
   logic ptr_load_ready_out;
   logic addr_valid_out;
   logic [31:0] addr_out;
   agu_wb_type writeback_out;
   logic [15:0] n_access;
   logic [31:0] pm [16] = '{default: 32'h0};
   int n_mismatch = 0;
   int n_compared = 0;
   int n_issued = 0;
   int cyc = 0;

   always #2 clk_in = ~clk_in;

   agu_core agu_core_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
      .ptr_load_valid_in(ptr_load_valid_in), .ptr_load_idx_in(ptr_load_idx_in),
      .ptr_load_data_in(ptr_load_data_in), .ptr_load_ready_out(ptr_load_ready_out),
      .addr_valid_out(addr_valid_out), .addr_out(addr_out), .writeback_out(writeback_out));

   agu_lsu_model agu_lsu_model_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .addr_valid_in(addr_valid_out), .addr_in(addr_out),
      .last_addr_out(), .n_access_out(n_access));

   // ******
   // Compare and drive helpers
   // ******
   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask : cmp_word

   task automatic cmp_wb(input agu_wb_type exp, input agu_wb_type got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED writeback exp %h got %h", exp, got);
      end
   endtask : cmp_wb

   function automatic agu_req_type mk(input agu_field_sel_type s, input logic [31:0] v,
                                      input logic [1:0] sz);
      agu_req_type r;
      r = '0;
      r.sel = s;
      r.size_log2 = sz;
      r.long_mode_field = v[15:0];
      r.short_mode_field = v[4:0];
      r.scaled_mode_field = v[11:0];
      r.direct_mode_field.imm = v;
      return r;
   endfunction : mk

   function automatic agu_req_type lg(input logic [15:0] f);
      return mk(AGU_SEL_LONG, {16'h0, f}, 2'h0);
   endfunction : lg

   function automatic agu_req_type sh(input logic [2:0] op, input logic [1:0] z);
      return mk(AGU_SEL_SHORT, {27'h0, op, z}, z);
   endfunction : sh

   task automatic load_ptr(input logic [3:0] k, input logic [31:0] d);
      @(posedge clk_in);
      ptr_load_valid_in <= 1'b1;
      ptr_load_idx_in <= k;
      ptr_load_data_in <= d;
      @(posedge clk_in);
      ptr_load_valid_in <= 1'b0;
      pm[k] = d;
   endtask : load_ptr

   // One request, judged on the pulse; the mirror follows write-back
   task automatic issue(input agu_req_type r, input logic [31:0] ea, input logic we,
                        input logic [3:0] wi, input logic [31:0] wd);
      int k;
      @(posedge clk_in);
      req_valid_in <= 1'b1;
      req_in <= r;
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      k = 0;
      do begin
         @(negedge clk_in);
         k++;
      end while (!addr_valid_out && k < 6);
      cmp_word("latency", 32'h2, k);
      cmp_word("addr", ea, addr_out);
      if (we) begin
         cmp_wb('{en: 1'b1, idx: wi, data: wd}, writeback_out);
         pm[wi] = wd;
      end else begin
         cmp_word("wb_en", 32'h0, {31'h0, writeback_out.en});
      end
      n_issued++;
   endtask : issue

   // ******
   // Scenarios
   // ******
   task automatic t_reset;
      @(negedge clk_in);
      cmp_word("ready", 32'h1, {31'h0, req_ready_out});
      cmp_word("load_ready", 32'h1, {31'h0, ptr_load_ready_out});
      cmp_word("addr_valid", 32'h0, {31'h0, addr_valid_out});
      cmp_word("addr", 32'h0, addr_out);
      cmp_wb('0, writeback_out);
   endtask : t_reset

   task automatic t_direct;
      agu_req_type r;
      r = mk(AGU_SEL_DIRECT, 32'hdead_beef, 2'h0);
      issue(r, 32'hdead_beef, 1'b0, 4'h0, 32'h0);
      load_ptr(4'h3, 32'hf000_0010);
      r.direct_mode_field.ptr_en = 1'b1;
      r.direct_mode_field.ptr = 4'h3;
      r.direct_mode_field.imm = 32'hffff_fff0;
      issue(r, 32'h0000_0000, 1'b0, 4'h0, 32'h0);
   endtask : t_direct

   task automatic t_offsets;
      load_ptr(4'h2, 32'h1000_0000);
      issue(lg({2'h0, 10'h3ff, 4'h2}), pm[2] + 32'h3ff, 1'b0, 4'h0, 32'h0);
      issue(lg({2'h1, 10'h3ff, 4'h2}), pm[2] + 32'hffc, 1'b0, 4'h0, 32'h0);
      issue(mk(AGU_SEL_SCALED, {20'h0, 8'hff, 4'h2}, 2'h0), pm[2] + 32'h3fc,
            1'b0, 4'h0, 32'h0);
   endtask : t_offsets

   task automatic t_indexed;
      load_ptr(4'h1, 32'h0000_0003);
      load_ptr(4'h2, 32'hffff_fff8);
      for (int s = 0; s < 4; s++) begin
         issue(lg({4'hf, 4'hf, s[1:0], 2'h1, 4'h2}), pm[2] + (pm[1] << s),
               1'b0, 4'h0, 32'h0);
      end
      issue(lg({4'hf, 4'he, 2'h3, 2'h1, 4'h2}), 32'h10, 1'b1, 4'he, 32'h10);
      issue(lg({3'h4, 7'h7f, 2'h1, 4'h2}), pm[2] + 32'h7f, 1'b1, 4'h2, pm[2] + pm[1]);
   endtask : t_indexed

   task automatic t_incdec;
      load_ptr(4'h5, 32'h0000_0080);
      issue(lg({4'hc, 8'hff, 4'h5}), pm[5], 1'b1, 4'h5, pm[5] + 32'hff);
      issue(lg({4'hd, 8'hff, 4'h5}), pm[5], 1'b1, 4'h5, pm[5] - 32'h100);
      issue(lg({4'he, 8'h00, 4'h5}), pm[5] - 32'h1, 1'b1, 4'h5, pm[5] - 32'h1);
   endtask : t_incdec

   // The decoder never names the stack pointer where it is invalid
   task automatic t_stack;
      load_ptr(4'hf, 32'h0000_1000);
      issue(lg({3'h5, 13'h1fff}), pm[15] - 32'h2000, 1'b0, 4'h0, 32'h0);
      issue(lg({4'hc, 8'h10, 4'hf}), pm[15], 1'b1, 4'hf, pm[15] + 32'h10);
      issue(lg({4'he, 8'hff, 4'hf}), pm[15] - 32'h100, 1'b1, 4'hf, pm[15] - 32'h100);
   endtask : t_stack

   // Every access size, each on its own short base 4 to 7
   task automatic t_short;
      logic [3:0] p;
      load_ptr(4'h0, 32'h0000_0010);
      load_ptr(4'h1, 32'h0000_0020);
      for (int z = 0; z < 4; z++) begin
         p = 4'h4 + 4'(z);
         load_ptr(p, 32'h0000_0100);
         issue(sh(3'h0, z[1:0]), pm[p], 1'b0, 4'h0, 32'h0);
         issue(sh(3'h1, z[1:0]), pm[p] + (pm[0] << z), 1'b0, 4'h0, 32'h0);
         issue(sh(3'h2, z[1:0]), pm[p] + (pm[1] << z), 1'b0, 4'h0, 32'h0);
         issue(sh(3'h3, z[1:0]), pm[p], 1'b1, p, pm[p] + (32'h1 << z));
         issue(sh(3'h4, z[1:0]), pm[p], 1'b1, p, pm[p] - (32'h1 << z));
         issue(sh(3'h5, z[1:0]), pm[p] - (32'h1 << z), 1'b1, p, pm[p] - (32'h1 << z));
         issue(sh(3'h6, z[1:0]), pm[p], 1'b1, p, pm[p] + pm[0]);
         issue(sh(3'h7, z[1:0]), pm[p], 1'b1, p, pm[p] + pm[1]);
      end
   endtask : t_short

   // ******
   // Verdict and hang guard
   // ******
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         final_report();
      end
   end

   // Main sequence
   initial begin
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_reset();
      t_direct();
      t_offsets();
      t_indexed();
      t_incdec();
      t_stack();
      t_short();
      @(negedge clk_in);
      cmp_word("accesses", n_issued, {16'h0, n_access});
      final_report();
   end
endmodule : address_generation_unit_tb

bind agu_core agu_core_checker agu_core_checker_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
   .ptr_load_valid_in(ptr_load_valid_in), .ptr_load_idx_in(ptr_load_idx_in),
   .ptr_load_data_in(ptr_load_data_in), .ptr_load_ready_out(ptr_load_ready_out),
   .addr_valid_out(addr_valid_out), .addr_out(addr_out), .writeback_out(writeback_out));
